// *** hdl/ldoc_ctrl.sv ***
// Regulator enable and voltage select control.
// Assumes pins are asynchronous and the register port is on sys_clk.
// Notes on behaviour
// - Select bit 0 is 1.3 V, 1 is 1.05 V
// - USB enable 0 turns off, pin Hi-Z
// - Control bits 15:2 read zero, ignore writes
// - Bandgap shutdown turns all regulators off
// - Regulator shutdown turns all regulators off
// - No shutdown, USB off, strap low: ana+core
// - Analog only off through shutdown bits or reset
// - Decisions combine strap pin and register bits
// - USB regulator disabled after reset
// - Bandgap bit 2, regulator bit 1
// - Wakeup pin or alarm clears shutdown
`timescale 1ns/1ps
module ldoc_ctrl
  import ldoc_pkg::*;
(
  input  wire logic                     sys_clk,    // System clock, 10 MHz
  input  wire logic                     rst,        // Sync reset, active high
  input  wire ldoc_pkg::ldoc_bus_req_t  bus_req,    // Register request
  output logic [ldoc_pkg::LDOC_DATA_W-1:0] rdata,   // Read data, next cycle
  input  wire logic                     core_reg_strap_pin, // Strap, async
  input  wire logic                     wakeup_pin, // Wakeup, async, high
  input  wire logic                     rtc_alarm,  // Alarm pulse, same clock
  output ldoc_pkg::ldoc_reg_out_t       reg_out     // Regulator controls
);
  import ldoc_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic usb_en_r;              // USB regulator enable
  logic vsel_r;                // Core voltage select
  logic bsd_r;                 // Bandgap shutdown
  logic rsd_r;                 // Regulator shutdown
  logic usb_en_nxt;            // Next USB enable
  logic vsel_nxt;              // Next voltage select
  logic bsd_nxt;               // Next bandgap shutdown
  logic rsd_nxt;               // Next regulator shutdown
  logic [1:0] warm_r;          // Synchroniser fill after reset
  logic [1:0] warm_nxt;        // Next synchroniser fill
  logic strap_s;               // Synchronised strap
  logic wake_s;                // Synchronised wakeup
  logic [LDOC_DATA_W-1:0] rdata_nxt; // Next read data
  ldoc_reg_out_t          out_nxt;   // Next regulator controls

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  ldoc_sync2 u_sync_strap (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d_async (core_reg_strap_pin),
    .q_sync  (strap_s)
  );

  ldoc_sync2 u_sync_wake (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d_async (wakeup_pin),
    .q_sync  (wake_s)
  );

  // ==========================================================================
  // Address decode
  // ==========================================================================
  wire ctrl_hit = (bus_req.addr == LDOC_REG_CTRL_OFF);   // Control register
  wire pmgt_hit = (bus_req.addr == LDOC_REG_PMGT_OFF);   // Power mgmt register
  wire ctrl_wr  = bus_req.wr && ctrl_hit;                 // Control write
  wire pmgt_wr  = bus_req.wr && pmgt_hit;                 // Power mgmt write
  wire wake_ev  = wake_s || rtc_alarm;                    // Wake event

  // Only bits 1:0 are stored; upper bits dropped
  assign usb_en_nxt = ctrl_wr ? bus_req.wdata[LDOC_USB_EN_BIT] : usb_en_r;
  assign vsel_nxt   = ctrl_wr ? bus_req.wdata[LDOC_VSEL_BIT]   : vsel_r;
  // Wake event wins over a software set
  assign bsd_nxt = wake_ev ? 1'b0 :
                   (pmgt_wr ? bus_req.wdata[LDOC_BSD_BIT] : bsd_r);
  assign rsd_nxt = wake_ev ? 1'b0 :
                   (pmgt_wr ? bus_req.wdata[LDOC_RSD_BIT] : rsd_r);

  // ==========================================================================
  // Read mux
  // ==========================================================================
  wire [LDOC_DATA_W-1:0] ctrl_rd = {14'h0000, vsel_r, usb_en_r};
  wire [LDOC_DATA_W-1:0] pmgt_rd = {13'h0000, bsd_r, rsd_r, 1'b0};
  assign rdata_nxt = !bus_req.rd ? 16'h0000 :
                     ctrl_hit    ? ctrl_rd  :
                     pmgt_hit    ? pmgt_rd  : 16'h0000;

  // ==========================================================================
  // Regulator decision matrix
  // ==========================================================================
  // The pin synchronisers read zero for two edges after reset. Core and
  // USB wait for the real strap level, so a high strap can never let the
  // core regulator blip on right after reset.
  assign warm_nxt = {warm_r[0], 1'b1};                    // Fill after reset
  wire pins_ok = warm_r[1];                               // Sync valid
  wire shut = bsd_r || rsd_r;
  wire core_ok = !shut && pins_ok && !strap_s;
  assign out_nxt.ana_on    = !shut;
  assign out_nxt.core_on   = core_ok;
  assign out_nxt.usb_on    = core_ok && usb_en_r;
  assign out_nxt.usb_oe    = core_ok && usb_en_r;
  assign out_nxt.core_vsel = vsel_r;

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      usb_en_r <= LDOC_USB_EN_RST;
      vsel_r   <= LDOC_VSEL_RST;
      bsd_r    <= LDOC_SD_RST;
      rsd_r    <= LDOC_SD_RST;
      warm_r   <= 2'h0;                                   // Sync not filled
      rdata    <= 16'h0000;
      reg_out  <= '0;
    end else begin
      usb_en_r <= usb_en_nxt;
      vsel_r   <= vsel_nxt;
      bsd_r    <= bsd_nxt;
      rsd_r    <= rsd_nxt;
      warm_r   <= warm_nxt;
      rdata    <= rdata_nxt;
      reg_out  <= out_nxt;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Either shutdown bit turns every regulator off
  a_shutdown_all_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    (bsd_r || rsd_r) |=> !reg_out.ana_on && !reg_out.core_on
      && !reg_out.usb_on)
    else $error("Regulators on during shutdown");

  // Regulator shutdown releases the USB pin
  a_rsd_usb_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    rsd_r |=> !reg_out.usb_oe)
    else $error("USB driven during regulator shutdown");

  // Analog regulator has no switch of its own
  a_ana_on_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!bsd_r && !rsd_r) |=> reg_out.ana_on)
    else $error("Analog regulator off without shutdown");

  // High strap keeps the core regulator off
  a_strap_core_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!shut && strap_s) |=> !reg_out.core_on && reg_out.ana_on)
    else $error("Core on with strap high");

  // Core and USB stay off until the strap level is known
  a_core_warm_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    !pins_ok |=> !reg_out.core_on && !reg_out.usb_oe)
    else $error("Core on before strap level known");

  // Strap low, USB disabled: analog and core only
  a_strap_low_on: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!shut && pins_ok && !strap_s && !usb_en_r) |=> reg_out.ana_on
      && reg_out.core_on && !reg_out.usb_on)
    else $error("Wrong regulators with strap low and USB off");

  // Strap low, USB enabled: all three on
  a_all_on_case: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!shut && pins_ok && !strap_s && usb_en_r) |=> reg_out.usb_on
      && reg_out.core_on && reg_out.ana_on)
    else $error("Not all regulators on");

  // USB disabled: regulator off and pin released
  a_usb_off_hiz: assert property (
    @(posedge sys_clk) disable iff (rst)
    !usb_en_r |=> !reg_out.usb_on && !reg_out.usb_oe)
    else $error("USB active while disabled");

  // A written select reaches the output two edges later
  a_vsel_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_wr |=> ##1
      reg_out.core_vsel == $past(bus_req.wdata[LDOC_VSEL_BIT], 2))
    else $error("Voltage select not applied");

  // The select holds while no control write arrives
  a_vsel_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !ctrl_wr |=> $stable(vsel_r))
    else $error("Voltage select moved without a write");

  // Control read-back holds select and enable only
  a_ctrl_readback: assert property (
    @(posedge sys_clk) disable iff (rst)
    (bus_req.rd && ctrl_hit) |=> rdata == {14'h0000, vsel_r, usb_en_r}
      && rdata[15:2] == 14'h0000)
    else $error("Control readback wrong");

  // Power register read-back shows the two shutdown bits
  a_pmgt_readback: assert property (
    @(posedge sys_clk) disable iff (rst)
    (bus_req.rd && pmgt_hit) |=>
      rdata == {13'h0000, $past(bsd_r), $past(rsd_r), 1'b0})
    else $error("Power register readback wrong");

  // Read data is zero outside the answer cycle
  a_rdata_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    !bus_req.rd |=> rdata == 16'h0000)
    else $error("Read data not zero outside a read");

  // Wake pin or alarm clears both shutdown bits
  a_wake_clears: assert property (
    @(posedge sys_clk) disable iff (rst)
    wake_ev |=> !bsd_r && !rsd_r)
    else $error("Wake did not clear shutdown");

  // Reset leaves the USB regulator off and its pin released
  a_reset_usb_off: assert property (
    @(posedge sys_clk)
    rst |=> !reg_out.usb_on && !reg_out.usb_oe)
    else $error("USB on after reset");

endmodule // ldoc_ctrl

// *** hdl/ldoc_sync2.sv ***
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module ldoc_sync2 (
  input  wire logic sys_clk,   // System clock
  input  wire logic rst,       // Synchronous reset, active high
  input  wire logic d_async,   // Asynchronous level
  output logic      q_sync     // Synchronised level
);

  logic meta_r;                // First stage, read only by second

  // ==========================================================================
  // Two-stage capture
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      q_sync <= 1'b0;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule // ldoc_sync2

// *** inc/ldoc_pkg.sv ***
// Package for the regulator enable control block.
// Assumes a 16-bit register port and a single system clock.
package ldoc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [15:0] LDOC_REG_CTRL_OFF = 16'h7004; // Regulator control
  localparam logic [15:0] LDOC_REG_PMGT_OFF = 16'h1930; // RTC power mgmt
  localparam int          LDOC_DATA_W       = 16;       // Register data width

  // Regulator control fields
  localparam int LDOC_USB_EN_BIT = 0;                   // USB regulator enable
  localparam int LDOC_VSEL_BIT   = 1;                   // Core voltage select
  // RTC power management fields
  localparam int LDOC_RSD_BIT    = 1;                   // Regulator shutdown
  localparam int LDOC_BSD_BIT    = 2;                   // Bandgap shutdown

  // Reset values
  localparam logic LDOC_USB_EN_RST = 1'b0;              // USB regulator off
  localparam logic LDOC_VSEL_RST   = 1'b0;              // 1.3 V target
  localparam logic LDOC_SD_RST     = 1'b0;              // No shutdown

  // Voltage select encodings
  localparam logic LDOC_VSEL_1V30 = 1'b0;               // 1.3 V
  localparam logic LDOC_VSEL_1V05 = 1'b1;               // 1.05 V

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;                                  // Register address
    logic [15:0] wdata;                                 // Write data
    logic        wr;                                    // Write strobe
    logic        rd;                                    // Read strobe
  } ldoc_bus_req_t;

  // Regulator outputs
  typedef struct packed {
    logic ana_on;                                       // Analog regulator on
    logic core_on;                                      // Core regulator on
    logic usb_on;                                       // USB regulator on
    logic usb_oe;                                       // USB pin driven
    logic core_vsel;                                    // Core voltage select
  } ldoc_reg_out_t;

endpackage

// *** verif/ldo_enable_control_tb.sv ***
// Self-checking bench for the regulator enable control block.
// Assumes ldoc_pkg and ldoc_ctrl are compiled before this file.
`timescale 1ns/1ps
module ldo_enable_control_tb;
  import ldoc_pkg::*;
  // ==========================================================================
  // Signals and model state
  // ==========================================================================
  logic          sys_clk;  // System clock, 100 ns
  logic          rst;      // Sync reset
  logic          strap;    // Core strap pin level
  logic          wake;     // Wakeup pin level
  logic          alarm;    // Alarm pulse
  ldoc_bus_req_t req;      // Register request
  logic [15:0]   rdata;    // Read data
  ldoc_reg_out_t rout;     // Regulator controls
  logic [15:0]   seed_r;   // Random state
  logic [15:0]   d;        // Random word written, bytes swapped for power mgmt
  logic          usb_m;    // Expected USB enable
  logic          vsel_m;   // Expected voltage select
  logic          bsd_m;    // Expected bandgap shutdown
  logic          rsd_m;    // Expected regulator shutdown
  int            n_fail;   // Mismatches
  int            compares; // Comparisons made

  ldoc_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .bus_req(req),
    .rdata(rdata), .core_reg_strap_pin(strap), .wakeup_pin(wake),
    .rtc_alarm(alarm), .reg_out(rout));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Random source, shifted once per draw
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected controls from shutdown bits, enable, select and strap
  function automatic logic [15:0] exp_out();
    ldoc_reg_out_t e;
    e.ana_on = !(bsd_m | rsd_m);
    e.core_on = e.ana_on & !strap;
    e.usb_on = e.core_on & usb_m;
    e.usb_oe = e.usb_on;
    e.core_vsel = vsel_m;
    return 16'(e);
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus cycle, write when w is high, read otherwise
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [15:0] dat);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: dat, wr: w, rd: !w};
    @(posedge sys_clk);
    req <= '0;
  endtask

  // Read and compare the word that stands after the taking edge
  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    #1;
    chk(nm, exp, rdata);
  endtask

  // Let sync and output stages settle, then compare controls
  task automatic settle_chk();
    repeat (5) @(posedge sys_clk);
    #1;
    chk("reg_out", exp_out(), 16'(rout));
  endtask

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {rst, strap, wake, alarm, usb_m, vsel_m, bsd_m, rsd_m} = 8'h80;
    req = '0;
    n_fail = 0;
    compares = 0;
    seed_r = 16'h004E;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    settle_chk();
    rd_chk("ctrl", LDOC_REG_CTRL_OFF, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      seed_r = lfsr(seed_r);
      d = (i == 0) ? 16'hFFFF : seed_r;
      @(posedge sys_clk);             // Pins move on a rising edge
      strap <= d[15] & d[14];
      bus(1'b1, LDOC_REG_CTRL_OFF, d);
      {vsel_m, usb_m} = d[1:0];
      bus(1'b1, LDOC_REG_PMGT_OFF, {d[7:0], d[15:8]});
      {bsd_m, rsd_m} = d[10:9];
      settle_chk();
      rd_chk("ctrl", LDOC_REG_CTRL_OFF, d & 16'h0003);
      rd_chk("pmgt", LDOC_REG_PMGT_OFF, {13'h0000, d[10:9], 1'b0});
      if (bsd_m | rsd_m) begin
        @(posedge sys_clk);
        if (d[4]) begin
          wake <= 1'b1;
          repeat (3) @(posedge sys_clk);
          wake <= 1'b0;
        end else begin
          alarm <= 1'b1;
          @(posedge sys_clk);
          alarm <= 1'b0;
        end
        {bsd_m, rsd_m} = 2'h0;
        settle_chk();
        rd_chk("pmgt", LDOC_REG_PMGT_OFF, 16'h0000);
      end
    end
    bus(1'b1, 16'h7006, 16'hFFFF);
    rd_chk("unmapped", 16'h7006, 16'h0000);
    rd_chk("ctrl", LDOC_REG_CTRL_OFF, {14'h0000, vsel_m, usb_m});
    // Reset mid-run with USB enabled and strap high: the core regulator
    // must stay off from the first edge, and USB must come back disabled
    bus(1'b1, LDOC_REG_CTRL_OFF, 16'h0001);
    strap <= 1'b1;
    rst   <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    {usb_m, vsel_m, bsd_m, rsd_m} = 4'h0;
    repeat (2) begin
      @(posedge sys_clk);
      #1;
      chk("reg_out", exp_out(), 16'(rout));
    end
    rd_chk("ctrl", LDOC_REG_CTRL_OFF, 16'h0000);
    // Slow parts switch the core regulator to 1.05 V after reset
    bus(1'b1, LDOC_REG_CTRL_OFF, 16'h0002);
    vsel_m = 1'b1;
    strap <= 1'b0;
    settle_chk();
    tally_and_finish();
  end
endmodule // ldo_enable_control_tb
